// ---- core/ecit_regs.vh ----
`ifndef ECIT_REGS_VH
`define ECIT_REGS_VH

// Register byte addresses.
`define ECIT_ADDR_CAP0_RISE 8'h22
`define ECIT_ADDR_CAP1_RISE 8'h23
`define ECIT_ADDR_CAP0_FALL 8'h24
`define ECIT_ADDR_CAP1_FALL 8'h25
`define ECIT_ADDR_IVL_CNT_LO 8'h26
`define ECIT_ADDR_IVL_CNT_HI 8'h27
`define ECIT_ADDR_IVL_RLD_LO 8'h28
`define ECIT_ADDR_IVL_RLD_HI 8'h29
`define ECIT_ADDR_CONFIG 8'h2A
`define ECIT_ADDR_IRQ_EN 8'h2B
`define ECIT_ADDR_IRQ_STAT 8'h2C
`define ECIT_ADDR_IVL_STAT 8'h2D
`define ECIT_ADDR_TIME_LO 8'h2E
`define ECIT_ADDR_TIME_HI 8'h2F

// Configuration field positions.
`define ECIT_CFG_HOLD_BIT 7
`define ECIT_CFG_PRESC_HI 6
`define ECIT_CFG_PRESC_LO 4
`define ECIT_CFG_WIDE_BIT 3
`define ECIT_CFG_MASK 8'hF8

// Capture event bit positions in enable and status.
`define ECIT_EV_C0_RISE 0
`define ECIT_EV_C0_FALL 1
`define ECIT_EV_C1_RISE 2
`define ECIT_EV_C1_FALL 3

`define ECIT_RST_BYTE 8'h00
`define ECIT_RST_WORD12 12'h000
`define ECIT_RST_WORD16 16'h0000

`endif

// ---- core/ecit_core.v ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "ecit_regs.vh"

module ecit_core (
  input wire ref_clk,
  input wire rst,
  input wire time_base_clock,
  input wire capture_input_a,
  input wire capture_input_b,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output wire capture_irq,
  output wire interval_irq
);

  reg [7:0] capture0_rise_time;
  reg [7:0] capture1_rise_time;
  reg [7:0] capture0_fall_time;
  reg [7:0] capture1_fall_time;
  reg [3:0] cap_full;
  reg [11:0] interval_count;
  reg [3:0] count_high_hold;
  reg [7:0] interval_reload_low;
  reg [3:0] interval_reload_high;
  reg [11:0] interval_reload;
  reg [7:0] capture_config;
  reg [3:0] capture_irq_enable;
  reg [3:0] capture_irq_status;
  reg interval_status;
  reg interval_mask;
  reg [15:0] time_base;
  reg [7:0] time_hi_hold;
  reg tb_clk_s1;
  reg tb_clk_s2;
  reg tb_clk_s3;
  reg in_a_d;
  reg in_b_d;

  wire hold_mode;
  wire wide_mode;
  wire [2:0] prescale;
  wire tb_tick;
  wire a_rise;
  wire a_fall;
  wire b_rise;
  wire b_fall;
  wire [3:0] cap_event;
  wire [3:0] cap_load;
  wire [3:0] cap_read;
  wire [7:0] narrow_time;
  wire interval_wrap;
  wire [3:0] stat_clear;

  // Window of the time base selected by the prescale code.
  function [7:0] ecit_window;
    input [15:0] tb;
    input [2:0] sel;
    begin
      ecit_window = tb[sel +: 8];
    end
  endfunction

  function is_read;
    input [7:0] a;
    input [7:0] target;
    input strobe;
    begin
      is_read = strobe && (a == target);
    end
  endfunction

  assign hold_mode = capture_config[`ECIT_CFG_HOLD_BIT];
  assign wide_mode = capture_config[`ECIT_CFG_WIDE_BIT];
  assign prescale = capture_config[`ECIT_CFG_PRESC_HI:`ECIT_CFG_PRESC_LO];

  // The capture clock is sampled as a level and its rising edge drives a
  // time base in the register clock domain. It must run below half of ref_clk.
  always @(posedge ref_clk) begin
    if (rst) begin
      tb_clk_s1 <= 1'b0;
      tb_clk_s2 <= 1'b0;
      tb_clk_s3 <= 1'b0;
    end else begin
      tb_clk_s1 <= time_base_clock;
      tb_clk_s2 <= tb_clk_s1;
      tb_clk_s3 <= tb_clk_s2;
    end
  end
  assign tb_tick = tb_clk_s2 & ~tb_clk_s3;

  always @(posedge ref_clk) begin
    if (rst) begin
      time_base <= `ECIT_RST_WORD16;
    end else if (tb_tick) begin
      time_base <= time_base + 16'h0001;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      in_a_d <= 1'b0;
      in_b_d <= 1'b0;
    end else begin
      in_a_d <= capture_input_a;
      in_b_d <= capture_input_b;
    end
  end

  assign a_rise = capture_input_a & ~in_a_d;
  assign a_fall = ~capture_input_a & in_a_d;
  // Input b is ignored entirely while the channels are joined.
  assign b_rise = capture_input_b & ~in_b_d & ~wide_mode;
  assign b_fall = ~capture_input_b & in_b_d & ~wide_mode;
  assign cap_event = {b_fall, b_rise, a_fall, a_rise};

  assign cap_read[`ECIT_EV_C0_RISE] = is_read(addr, `ECIT_ADDR_CAP0_RISE, rd);
  assign cap_read[`ECIT_EV_C0_FALL] = is_read(addr, `ECIT_ADDR_CAP0_FALL, rd);
  assign cap_read[`ECIT_EV_C1_RISE] = is_read(addr, `ECIT_ADDR_CAP1_RISE, rd);
  assign cap_read[`ECIT_EV_C1_FALL] = is_read(addr, `ECIT_ADDR_CAP1_FALL, rd);

  // In wide mode a channel 0 edge also fills the channel 1 register, so hold
  // for the pair follows the channel 0 register alone.
  assign cap_load[`ECIT_EV_C0_RISE] = a_rise & (~hold_mode | ~cap_full[`ECIT_EV_C0_RISE]);
  assign cap_load[`ECIT_EV_C0_FALL] = a_fall & (~hold_mode | ~cap_full[`ECIT_EV_C0_FALL]);
  assign cap_load[`ECIT_EV_C1_RISE] = b_rise & (~hold_mode | ~cap_full[`ECIT_EV_C1_RISE]);
  assign cap_load[`ECIT_EV_C1_FALL] = b_fall & (~hold_mode | ~cap_full[`ECIT_EV_C1_FALL]);

  assign narrow_time = ecit_window(time_base, prescale);

  always @(posedge ref_clk) begin
    if (rst) begin
      capture0_rise_time <= `ECIT_RST_BYTE;
      capture1_rise_time <= `ECIT_RST_BYTE;
      capture0_fall_time <= `ECIT_RST_BYTE;
      capture1_fall_time <= `ECIT_RST_BYTE;
    end else if (wide_mode) begin
      if (cap_load[`ECIT_EV_C0_RISE]) begin
        capture0_rise_time <= time_base[7:0];
        capture1_rise_time <= time_base[15:8];
      end
      if (cap_load[`ECIT_EV_C0_FALL]) begin
        capture0_fall_time <= time_base[7:0];
        capture1_fall_time <= time_base[15:8];
      end
    end else begin
      if (cap_load[`ECIT_EV_C0_RISE]) begin
        capture0_rise_time <= narrow_time;
      end
      if (cap_load[`ECIT_EV_C0_FALL]) begin
        capture0_fall_time <= narrow_time;
      end
      if (cap_load[`ECIT_EV_C1_RISE]) begin
        capture1_rise_time <= narrow_time;
      end
      if (cap_load[`ECIT_EV_C1_FALL]) begin
        capture1_fall_time <= narrow_time;
      end
    end
  end

  // A load in the same cycle as a read wins, so a fresh edge is not lost.
  always @(posedge ref_clk) begin
    if (rst) begin
      cap_full <= 4'h0;
    end else begin
      cap_full <= (cap_full & ~cap_read) | cap_load;
    end
  end

  // Interval timer.
  assign interval_wrap = (interval_count == `ECIT_RST_WORD12);

  always @(posedge ref_clk) begin
    if (rst) begin
      interval_count <= `ECIT_RST_WORD12;
    end else if (interval_wrap) begin
      interval_count <= interval_reload;
    end else begin
      interval_count <= interval_count - 12'h001;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      count_high_hold <= 4'h0;
      time_hi_hold <= `ECIT_RST_BYTE;
    end else begin
      if (is_read(addr, `ECIT_ADDR_IVL_CNT_LO, rd)) begin
        count_high_hold <= interval_count[11:8];
      end
      if (is_read(addr, `ECIT_ADDR_TIME_LO, rd)) begin
        time_hi_hold <= time_base[15:8];
      end
    end
  end

  // The reload only takes effect as a whole when the high nibble is written,
  // so software writes the low byte first.
  always @(posedge ref_clk) begin
    if (rst) begin
      interval_reload_low <= `ECIT_RST_BYTE;
      interval_reload_high <= 4'h0;
      interval_reload <= `ECIT_RST_WORD12;
      capture_config <= `ECIT_RST_BYTE;
      capture_irq_enable <= 4'h0;
      interval_mask <= 1'b0;
    end else if (wr) begin
      case (addr)
        `ECIT_ADDR_IVL_RLD_LO: begin
          interval_reload_low <= wdata;
        end
        `ECIT_ADDR_IVL_RLD_HI: begin
          interval_reload_high <= wdata[3:0];
          interval_reload <= {wdata[3:0], interval_reload_low};
        end
        `ECIT_ADDR_CONFIG: begin
          capture_config <= wdata & `ECIT_CFG_MASK;
        end
        `ECIT_ADDR_IRQ_EN: begin
          capture_irq_enable <= wdata[3:0];
        end
        `ECIT_ADDR_IVL_STAT: begin
          interval_mask <= wdata[1];
        end
        default: begin
        end
      endcase
    end
  end

  assign stat_clear = (wr && addr == `ECIT_ADDR_IRQ_STAT) ? wdata[3:0] : 4'h0;

  // Set beats clear so an edge in the clearing cycle is kept.
  always @(posedge ref_clk) begin
    if (rst) begin
      capture_irq_status <= 4'h0;
      interval_status <= 1'b0;
    end else begin
      capture_irq_status <= (capture_irq_status & ~stat_clear) | cap_event;
      interval_status <= (interval_status & ~(wr && addr == `ECIT_ADDR_IVL_STAT && wdata[0])) | interval_wrap;
    end
  end

  assign capture_irq = |(capture_irq_status & capture_irq_enable);
  assign interval_irq = interval_status & interval_mask;

  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= `ECIT_RST_BYTE;
    end else if (rd) begin
      case (addr)
        `ECIT_ADDR_CAP0_RISE: rdata <= capture0_rise_time;
        `ECIT_ADDR_CAP1_RISE: rdata <= capture1_rise_time;
        `ECIT_ADDR_CAP0_FALL: rdata <= capture0_fall_time;
        `ECIT_ADDR_CAP1_FALL: rdata <= capture1_fall_time;
        `ECIT_ADDR_IVL_CNT_LO: rdata <= interval_count[7:0];
        `ECIT_ADDR_IVL_CNT_HI: rdata <= {4'h0, count_high_hold};
        `ECIT_ADDR_IVL_RLD_LO: rdata <= interval_reload_low;
        `ECIT_ADDR_IVL_RLD_HI: rdata <= {4'h0, interval_reload_high};
        `ECIT_ADDR_CONFIG: rdata <= capture_config;
        `ECIT_ADDR_IRQ_EN: rdata <= {4'h0, capture_irq_enable};
        `ECIT_ADDR_IRQ_STAT: rdata <= {4'h0, capture_irq_status};
        `ECIT_ADDR_IVL_STAT: rdata <= {6'h00, interval_mask, interval_status};
        `ECIT_ADDR_TIME_LO: rdata <= time_base[7:0];
        `ECIT_ADDR_TIME_HI: rdata <= time_hi_hold;
        default: rdata <= `ECIT_RST_BYTE;
      endcase
    end else begin
      rdata <= `ECIT_RST_BYTE;
    end
  end

endmodule // ecit_core

// ---- tb/ecit_chk.sv ----
`timescale 1ns/1ns
module ecit_chk (
  input wire ref_clk,
  input wire rst,
  input wire time_base_clock,
  input wire capture_input_a,
  input wire capture_input_b,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire capture_irq,
  input wire interval_irq
);
  reg [3:0] en_q;
  wire en_wr = wr && addr == 8'h2B;
  // The enable copy lets an edge be tied to the interrupt without peeking inside the design.
  always @(posedge ref_clk) begin
    if (rst) begin
      en_q <= 4'h0;
    end else if (en_wr) begin
      en_q <= wdata[3:0];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  AST_CNT_HI_RSVD: assert property (rd && addr == 8'h27 |=> rdata[7:4] == 4'h0)
    else $error("count high reserved bits set");
  AST_CFG_RSVD: assert property (rd && addr == 8'h2A |=> rdata[2:0] == 3'h0)
    else $error("config reserved bits set");
  AST_EN_RSVD: assert property (rd && addr == 8'h2B |=> rdata[7:4] == 4'h0)
    else $error("enable reserved bits set");
  AST_STAT_RSVD: assert property (rd && addr == 8'h2C |=> rdata[7:4] == 4'h0)
    else $error("status reserved bits set");
  AST_RISE_IRQ: assert property ($rose(capture_input_a) && en_q[0] && !en_wr |=> capture_irq)
    else $error("rise did not raise irq");
  AST_FALL_IRQ: assert property ($fell(capture_input_a) && en_q[1] && !en_wr |=> capture_irq)
    else $error("fall did not raise irq");
  AST_STAT_CLEAR: assert property (wr && addr == 8'h2C && wdata[3:0] == 4'hF && $stable(capture_input_a)
    && $stable(capture_input_b) |=> !capture_irq) else $error("clear left irq high");
  AST_NO_EN: assert property (en_wr && wdata[3:0] == 4'h0 |=> !capture_irq)
    else $error("irq high with no enable");
  cover property ($rose(capture_irq));
  cover property ($rose(interval_irq));
  cover property (rd && addr == 8'h27);
endmodule // ecit_chk

bind ecit_core ecit_chk u_chk (.ref_clk(ref_clk), .rst(rst), .time_base_clock(time_base_clock),
  .capture_input_a(capture_input_a), .capture_input_b(capture_input_b), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .capture_irq(capture_irq), .interval_irq(interval_irq));

// ---- tb/ecit_pins.sv ----
`timescale 1ns/1ns
module ecit_pins (
  input wire ref_clk,
  output reg capture_input_a,
  output reg capture_input_b
);
  initial begin
    capture_input_a = 1'b0;
    capture_input_b = 1'b0;
  end
  // Levels move just after an edge, since the block treats the pins as synchronous.
  task drive(input [1:0] v);
    begin
      @(posedge ref_clk);
      {capture_input_b, capture_input_a} <= v;
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule // ecit_pins

// ---- tb/ecit_core_bench.sv ----
`timescale 1ns/1ns
module ecit_core_bench;
  reg ref_clk, rst, time_base_clock, wr, rd;
  reg [7:0] addr, wdata, d;
  reg [15:0] t;
  wire [7:0] rdata;
  wire capture_input_a, capture_input_b, capture_irq, interval_irq;
  integer num_errors = 0, n_compared = 0, i, k;
  ecit_core u_dut (.ref_clk(ref_clk), .rst(rst), .time_base_clock(time_base_clock),
    .capture_input_a(capture_input_a), .capture_input_b(capture_input_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .capture_irq(capture_irq), .interval_irq(interval_irq));
  ecit_pins u_pins (.ref_clk(ref_clk), .capture_input_a(capture_input_a), .capture_input_b(capture_input_b));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task stop_test;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wreg(input [7:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
    end
  endtask
  // A plain read with no judgement, for values that a later check depends on.
  task peek(input [7:0] a);
    begin
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task chk(input [7:0] a, input [7:0] e);
    begin
      peek(a);
      cmp(d, e);
    end
  endtask
  // The time base only moves here, so a value read now is the one any later edge captures.
  task tick(input integer n);
    repeat (n) begin
      @(posedge ref_clk) time_base_clock <= 1'b1;
      repeat (2) @(posedge ref_clk);
      time_base_clock <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  task get_t;
    begin
      peek(8'h2E);
      t[7:0] = d;
      peek(8'h2F);
      t[15:8] = d;
    end
  endtask
  task pulse(input [1:0] v);
    begin
      u_pins.drive(v);
      u_pins.drive(2'b00);
    end
  endtask
  task regs_reset;
    begin
      for (k = 8'h22; k <= 8'h2C; k = k + 1)
        if (k != 8'h26) chk(k[7:0], 8'h00);
      chk(8'h30, 8'h00);
      wreg(8'h28, 8'hA5);
      chk(8'h28, 8'hA5);
      wreg(8'h29, 8'hFF);
      chk(8'h29, 8'h0F);
      wreg(8'h2A, 8'hFF);
      chk(8'h2A, 8'hF8);
      wreg(8'h2B, 8'hFF);
      chk(8'h2B, 8'h0F);
      wreg(8'h28, 8'h00);
      wreg(8'h29, 8'h00);
      wreg(8'h2A, 8'h00);
      wreg(8'h2B, 8'h00);
    end
  endtask
  task prescale_walk;
    for (i = 0; i < 8; i = i + 1) begin
      wreg(8'h2A, {1'b0, i[2:0], 4'h0});
      tick(1000);
      get_t;
      pulse(2'b11);
      chk(8'h22, t[i[2:0] +: 8]);
      chk(8'h23, t[i[2:0] +: 8]);
      chk(8'h24, t[i[2:0] +: 8]);
      chk(8'h25, t[i[2:0] +: 8]);
    end
  endtask
  task wide_mode;
    begin
      wreg(8'h2A, 8'h08);
      wreg(8'h2C, 8'h0F);
      tick(300);
      get_t;
      pulse(2'b11);
      chk(8'h24, t[7:0]);
      chk(8'h25, t[15:8]);
      chk(8'h23, t[15:8]);
      chk(8'h2C, 8'h03);
    end
  endtask
  task first_hold;
    begin
      wreg(8'h2A, 8'h80);
      chk(8'h24, t[7:0]);
      pulse(2'b01);
      get_t;
      tick(5);
      pulse(2'b01);
      chk(8'h24, t[7:0]);
      tick(5);
      get_t;
      pulse(2'b01);
      chk(8'h24, t[7:0]);
      wreg(8'h2A, 8'h00);
      wreg(8'h2C, 8'h0F);
      chk(8'h2C, 8'h00);
    end
  endtask
  task irq_events;
    for (i = 0; i < 4; i = i + 1) begin
      wreg(8'h2B, 8'h01 << i);
      u_pins.drive(i[0] ? 2'b00 : (i[1] ? 2'b10 : 2'b01));
      #1 cmp({7'h00, capture_irq}, 8'h01);
      chk(8'h2C, 8'h01 << i);
      wreg(8'h2B, 8'h00);
      #1 cmp({7'h00, capture_irq}, 8'h00);
      wreg(8'h2C, 8'h01 << i);
      chk(8'h2C, 8'h00);
    end
  endtask
  task interval_walk;
    begin
      wreg(8'h28, 8'h00);
      wreg(8'h29, 8'h03);
      repeat (254) @(posedge ref_clk);
      peek(8'h26);
      k = d[7] ? 1 : 2;
      repeat (8) @(posedge ref_clk);
      chk(8'h27, k[7:0]);
      wreg(8'h2D, 8'h03);
      #1 cmp({7'h00, interval_irq}, 8'h00);
      for (k = 0; k < 800 && interval_irq !== 1'b1; k = k + 1)
        @(posedge ref_clk) #1;
      cmp({7'h00, interval_irq}, 8'h01);
      if (k >= 800) stop_test;
    end
  endtask
  initial begin
    rst = 1'b1;
    time_base_clock = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    regs_reset;
    prescale_walk;
    wide_mode;
    first_hold;
    irq_events;
    interval_walk;
    stop_test;
  end
endmodule // ecit_core_bench
